// file: rtl/smc_consts.svh
// named constants for the stepper motion command block
// assumes a 50 MHz system clock and a 32-bit ahb-lite register bus
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SMC_OFS_MODE      8'h00
`define SMC_OFS_DIR       8'h04
`define SMC_OFS_RATE      8'h08
`define SMC_OFS_CUR       8'h0c
`define SMC_OFS_STEPS     8'h10
`define SMC_OFS_CFG       8'h14
`define SMC_OFS_ANGLE     8'h18
`define SMC_OFS_RATE_LIM  8'h1c
`define SMC_OFS_RATE_RX   8'h20
`define SMC_OFS_CUR_LIM   8'h24
`define SMC_OFS_CUR_RX    8'h28
`define SMC_OFS_STEPS_LIM 8'h2c
`define SMC_OFS_STEPS_RX  8'h30
`define SMC_OFS_STATUS    8'h34

// ----------------------------------------
// motor mode codes
// ----------------------------------------
`define SMC_MODE_DISABLED 3'h0
`define SMC_MODE_STOPPED  3'h1
`define SMC_MODE_RUNNING  3'h2
`define SMC_MODE_STEPPING 3'h3
`define SMC_MODE_HOLDING  3'h4

// ----------------------------------------
// field positions and values
// ----------------------------------------
`define SMC_DIR_REVERSE   1'b0
`define SMC_DIR_FORWARD   1'b1
`define SMC_CFG_UNIT_RPM  0
`define SMC_CFG_TMO_ZERO  1
`define SMC_CFG_MODE_PID  2
`define SMC_CFG_DIR_PID   3
`define SMC_CFG_RATE_PID  4
`define SMC_CFG_W         5

// ----------------------------------------
// reset values
// ----------------------------------------
`define SMC_RST_ANGLE     16'h0012
`define SMC_RST_RX        32'h0064_0000
`define SMC_RST_RATE_LIM  32'h03e8_0000
`define SMC_RST_CUR_LIM   32'h07d0_0000
`define SMC_RST_STEPS_MAX 16'h03e8
`define SMC_RST_CFG       5'h00

// ----------------------------------------
// timing and arithmetic
// ----------------------------------------
`define SMC_CLK_PERIOD_NS 20
`define SMC_CLK_HZ        (1000000000 / `SMC_CLK_PERIOD_NS)
`define SMC_STEP_PW_NS    1000
`define SMC_STEP_PW_CYC   ((`SMC_STEP_PW_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`define SMC_DEG_PER_REV   360
`define SMC_SEC_PER_MIN   60
`define SMC_QTR_PER_CYC   4

`endif

// file: rtl/smc_pkg.sv
// types shared by the stepper motion command block
// assumes nothing beyond a systemverilog compiler
package smc_pkg;

   // ----------------------------------------
   // drive-side outputs to the driver chip
   // ----------------------------------------
   typedef struct packed {
      logic        enable;   // phase current on
      logic        step;     // step pulse
      logic        dir;      // 1 forward, 0 reverse
      logic [15:0] current;  // peak phase current
   } smc_drv_type;

   // feedback towards the host
   typedef struct packed {
      logic [2:0]  mode;
      logic        steps_avail;
      logic [15:0] steps_left;
   } smc_fb_type;

   // commands from the pid controller
   typedef struct packed {
      logic [2:0]  mode;
      logic        dir;
      logic [15:0] rate;
   } smc_pid_type;

   // step engine states
   typedef enum logic [1:0] {
      ST_IDLE, ST_RUN, ST_STEP, ST_HOLD
   } smc_state_type;

endpackage

// file: rtl/smc_top.sv
// stepper motion command logic with ahb-lite register slave
// assumes one 50 MHz clock, pid inputs on the same clock
// How it works
// - mode codes 0..2 commanded, 3..4 feedback only
// - reset enters stopped mode
// - disabled removes current and resets stepping
// - rpm converted using step angle, default 18
// - nonzero count issues exactly that many steps
// - after count while running, hold current, report holding
// - zero count steps continuously while running
// - a changed count, or any count when none is held, starts a move
// - stopped to running restarts the move
// - zero timeout clears count availability after move
// - move end: stopped turns off, running holds
// - pid mode source forces pid direction, rate
// - current stays register driven under pid
// - direction 0 reverse, 1 forward, default forward
// - rate scaled linearly between min and max
// - rate unit selects steps/s or rpm
// - rate step is one full electrical cycle
// - phase current uses the same scaling
// - count scaled, minimum fixed at zero
// - counted step is a quarter cycle
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`include "smc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module smc_top
   import smc_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic [31:0]      o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // pid controller commands
   input  wire smc_pid_type i_pid,
   // driver chip and feedback
   output smc_drv_type      o_drv,
   output smc_fb_type       o_fb
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [7:0]          ap_addr_reg;    // latched address
   logic                ap_wr_reg;      // write data phase
   logic [2:0]          mode_reg;       // commanded mode
   logic                dir_reg;        // commanded direction
   logic [15:0]         rate_x_reg;     // received rate
   logic [15:0]         cur_x_reg;      // received current
   logic [15:0]         steps_x_reg;    // received count
   logic [`SMC_CFG_W-1:0] cfg_reg;      // config bits
   logic [15:0]         angle_reg;      // degrees per step
   logic [31:0]         rate_lim_reg;   // {max,min}
   logic [31:0]         rate_rx_reg;
   logic [31:0]         cur_lim_reg;
   logic [31:0]         cur_rx_reg;
   logic [15:0]         steps_max_reg;
   logic [31:0]         steps_rx_reg;
   logic                avail_reg;      // count data available
   logic [1:0]          arm_reg;        // move request pipe
   logic [2:0]          mode_prev_reg;
   logic [15:0]         cur_val_reg;    // scaled current
   logic [15:0]         steps_val_reg;  // scaled count
   logic [31:0]         period_reg;     // cycles per quarter
   logic [31:0]         tick_reg;
   logic [7:0]          pw_reg;         // pulse width left
   logic [15:0]         left_reg;       // steps still to go
   logic [15:0]         mv_cnt_reg;     // pulses this move
   logic [15:0]         mv_len_reg;     // length of this move
   smc_state_type       state_reg;
   logic [2:0]          mode_eff;
   logic                dir_eff;
   logic [15:0]         rate_eff;
   logic                running;
   logic                wr;
   logic                steps_wr_chg;
   logic                go_step;
   logic                fire;
   logic                done;
   logic [31:0]         sps;            // full cycles per second

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // y = m*x + a, done as ymin + (x-xmin)*(ymax-ymin)/(xmax-xmin)
   function automatic logic [15:0] scale(input logic [15:0] x,
                                         input logic [31:0] rx,
                                         input logic [31:0] lim);
      logic [15:0] xc;
      logic [31:0] num;
      xc = x;
      if (x < rx[15:0]) xc = rx[15:0];
      if (x > rx[31:16]) xc = rx[31:16];
      if (rx[31:16] <= rx[15:0] || lim[31:16] <= lim[15:0]) begin
         return lim[15:0];
      end
      num = 32'(xc - rx[15:0]) * 32'(lim[31:16] - lim[15:0]);
      return lim[15:0] + 16'(num / 32'(rx[31:16] - rx[15:0]));
   endfunction

   // register word select, shared by read and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a[7:2] == ofs[7:2];
   endfunction

   // ----------------------------------------
   // command sources
   // ----------------------------------------
   assign mode_eff = cfg_reg[`SMC_CFG_MODE_PID] ? i_pid.mode : mode_reg;
   assign dir_eff  = cfg_reg[`SMC_CFG_DIR_PID] ? i_pid.dir : dir_reg;
   assign rate_eff = cfg_reg[`SMC_CFG_RATE_PID] ? i_pid.rate
                   : scale(rate_x_reg, rate_rx_reg, rate_lim_reg);
   assign running  = mode_eff == `SMC_MODE_RUNNING;
   assign wr       = ap_wr_reg;
   // a write counts as new data when it differs or none was held
   assign steps_wr_chg = wr && hit(ap_addr_reg, `SMC_OFS_STEPS) &&
                         (!avail_reg || i_hwdata[15:0] != steps_x_reg);
   // rpm to full cycles per second through the step angle
   assign sps = !cfg_reg[`SMC_CFG_UNIT_RPM] ? 32'(rate_eff)
              : (angle_reg == 16'h0000) ? 32'h0000_0000
              : (32'(rate_eff) * `SMC_DEG_PER_REV) /
                (`SMC_SEC_PER_MIN * 32'(angle_reg));

   // ----------------------------------------
   // ahb-lite address phase and read data
   // ----------------------------------------
   // zero wait states, so read data is prepared at the address phase
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ap_addr_reg <= 8'h00;
         ap_wr_reg   <= 1'b0;
         o_hrdata    <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         ap_wr_reg   <= 1'b0;
         if (i_hsel && i_htrans[1] && i_hready) begin
            ap_addr_reg <= i_haddr[7:0];
            ap_wr_reg   <= i_hwrite;
            o_hrdata    <= 32'h0000_0000; // unmapped reads as zero
            if (!i_hwrite) begin
               unique case (1'b1)
                  hit(i_haddr[7:0], `SMC_OFS_MODE):      o_hrdata <= 32'(mode_reg);
                  hit(i_haddr[7:0], `SMC_OFS_DIR):       o_hrdata <= 32'(dir_reg);
                  hit(i_haddr[7:0], `SMC_OFS_RATE):      o_hrdata <= 32'(rate_x_reg);
                  hit(i_haddr[7:0], `SMC_OFS_CUR):       o_hrdata <= 32'(cur_x_reg);
                  hit(i_haddr[7:0], `SMC_OFS_STEPS):     o_hrdata <= 32'(steps_x_reg);
                  hit(i_haddr[7:0], `SMC_OFS_CFG):       o_hrdata <= 32'(cfg_reg);
                  hit(i_haddr[7:0], `SMC_OFS_ANGLE):     o_hrdata <= 32'(angle_reg);
                  hit(i_haddr[7:0], `SMC_OFS_RATE_LIM):  o_hrdata <= rate_lim_reg;
                  hit(i_haddr[7:0], `SMC_OFS_RATE_RX):   o_hrdata <= rate_rx_reg;
                  hit(i_haddr[7:0], `SMC_OFS_CUR_LIM):   o_hrdata <= cur_lim_reg;
                  hit(i_haddr[7:0], `SMC_OFS_CUR_RX):    o_hrdata <= cur_rx_reg;
                  // minimum count reads as fixed zero
                  hit(i_haddr[7:0], `SMC_OFS_STEPS_LIM): o_hrdata <= {steps_max_reg, 16'h0000};
                  hit(i_haddr[7:0], `SMC_OFS_STEPS_RX):  o_hrdata <= steps_rx_reg;
                  hit(i_haddr[7:0], `SMC_OFS_STATUS):    o_hrdata <= 32'(o_fb);
                  default:                               o_hrdata <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mode_reg      <= `SMC_MODE_STOPPED;
         dir_reg       <= `SMC_DIR_FORWARD;
         rate_x_reg    <= 16'h0000;
         cur_x_reg     <= 16'h0000;
         steps_x_reg   <= 16'h0000;
         cfg_reg       <= `SMC_RST_CFG;
         angle_reg     <= `SMC_RST_ANGLE;
         rate_lim_reg  <= `SMC_RST_RATE_LIM;
         rate_rx_reg   <= `SMC_RST_RX;
         cur_lim_reg   <= `SMC_RST_CUR_LIM;
         cur_rx_reg    <= `SMC_RST_RX;
         steps_max_reg <= `SMC_RST_STEPS_MAX;
         steps_rx_reg  <= `SMC_RST_RX;
      end else if (wr) begin
         unique case (1'b1)
            // feedback-only codes are refused as commands
            hit(ap_addr_reg, `SMC_OFS_MODE):
               if (i_hwdata[2:0] <= `SMC_MODE_RUNNING) mode_reg <= i_hwdata[2:0];
            hit(ap_addr_reg, `SMC_OFS_DIR):       dir_reg <= i_hwdata[0];
            hit(ap_addr_reg, `SMC_OFS_RATE):      rate_x_reg <= i_hwdata[15:0];
            hit(ap_addr_reg, `SMC_OFS_CUR):       cur_x_reg <= i_hwdata[15:0];
            hit(ap_addr_reg, `SMC_OFS_STEPS):     steps_x_reg <= i_hwdata[15:0];
            hit(ap_addr_reg, `SMC_OFS_CFG): begin
               cfg_reg <= i_hwdata[`SMC_CFG_W-1:0];
               // pid mode drags direction and rate along
               if (i_hwdata[`SMC_CFG_MODE_PID]) begin
                  cfg_reg[`SMC_CFG_DIR_PID]  <= 1'b1;
                  cfg_reg[`SMC_CFG_RATE_PID] <= 1'b1;
               end
            end
            hit(ap_addr_reg, `SMC_OFS_ANGLE):     angle_reg <= i_hwdata[15:0];
            hit(ap_addr_reg, `SMC_OFS_RATE_LIM):  rate_lim_reg <= i_hwdata;
            hit(ap_addr_reg, `SMC_OFS_RATE_RX):   rate_rx_reg <= i_hwdata;
            hit(ap_addr_reg, `SMC_OFS_CUR_LIM):   cur_lim_reg <= i_hwdata;
            hit(ap_addr_reg, `SMC_OFS_CUR_RX):    cur_rx_reg <= i_hwdata;
            hit(ap_addr_reg, `SMC_OFS_STEPS_LIM): steps_max_reg <= i_hwdata[31:16];
            hit(ap_addr_reg, `SMC_OFS_STEPS_RX):  steps_rx_reg <= i_hwdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // scaled values and step period
   // ----------------------------------------
   // registered to keep the dividers off the control path
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cur_val_reg   <= 16'h0000;
         steps_val_reg <= 16'h0000;
         period_reg    <= 32'h0000_0000;
      end else begin
         // current ignores the pid sources entirely
         cur_val_reg   <= scale(cur_x_reg, cur_rx_reg, cur_lim_reg);
         steps_val_reg <= scale(steps_x_reg, steps_rx_reg,
                                {steps_max_reg, 16'h0000});
         // quarter-cycle pulses, four per full cycle of rate
         period_reg    <= (sps == 32'h0000_0000) ? 32'h0000_0000
                        : `SMC_CLK_HZ / (sps * `SMC_QTR_PER_CYC);
      end
   end

   // ----------------------------------------
   // move requests and data availability
   // ----------------------------------------
   // two stages let the scaled count settle before it is used
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         arm_reg       <= 2'b00;
         mode_prev_reg <= `SMC_MODE_STOPPED;
      end else begin
         mode_prev_reg <= mode_eff;
         arm_reg[1]    <= arm_reg[0] && mode_eff != `SMC_MODE_DISABLED;
         arm_reg[0]    <= steps_wr_chg ||
                          (mode_prev_reg == `SMC_MODE_STOPPED && running);
      end
   end

   // new data wins over the clear at move end
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         avail_reg <= 1'b0;
      end else if (wr && hit(ap_addr_reg, `SMC_OFS_STEPS)) begin
         avail_reg <= 1'b1;
      end else if (done && cfg_reg[`SMC_CFG_TMO_ZERO]) begin
         avail_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // step engine state
   // ----------------------------------------
   assign go_step = arm_reg[1] && steps_val_reg != 16'h0000 &&
                    state_reg != ST_STEP && mode_eff != `SMC_MODE_DISABLED;
   assign fire    = (state_reg == ST_RUN || (state_reg == ST_STEP && left_reg != 16'h0000)) &&
                    period_reg != 32'h0000_0000 && pw_reg == 8'h00 && tick_reg >= period_reg;
   assign done    = state_reg == ST_STEP && left_reg == 16'h0000 && pw_reg == 8'h00;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
      end else if (mode_eff == `SMC_MODE_DISABLED) begin
         state_reg <= ST_IDLE;
      end else if (go_step) begin
         state_reg <= ST_STEP;
      end else begin
         unique case (state_reg)
            ST_IDLE: if (running && steps_val_reg == 16'h0000) state_reg <= ST_RUN;
            ST_RUN:  if (!running || steps_val_reg != 16'h0000) state_reg <= ST_IDLE;
            // a finished move holds if running, else powers down
            ST_STEP: if (done) state_reg <= running ? ST_HOLD : ST_IDLE;
            ST_HOLD: begin
               if (!running) state_reg <= ST_IDLE;
               else if (steps_val_reg == 16'h0000) state_reg <= ST_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------
   // pulse timing and counting
   // ----------------------------------------
   // a short period still yields the full pulse width, so the
   // real rate saturates near the pulse-width frequency
   always_ff @(posedge i_clk) begin
      if (i_rst || mode_eff == `SMC_MODE_DISABLED) begin
         tick_reg   <= 32'h0000_0000;
         pw_reg     <= 8'h00;
         left_reg   <= 16'h0000;
         mv_cnt_reg <= 16'h0000;
         mv_len_reg <= 16'h0000;
      end else begin
         tick_reg <= fire ? 32'h0000_0001 : tick_reg + 32'h0000_0001;
         if (fire) pw_reg <= 8'(`SMC_STEP_PW_CYC);
         else if (pw_reg != 8'h00) pw_reg <= pw_reg - 8'h01;
         if (go_step) begin
            left_reg   <= steps_val_reg;
            mv_len_reg <= steps_val_reg;
            mv_cnt_reg <= 16'h0000;
            tick_reg   <= 32'h0000_0000;
         end else if (fire && state_reg == ST_STEP) begin
            left_reg   <= left_reg - 16'h0001;
            mv_cnt_reg <= mv_cnt_reg + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_drv <= '{enable: 1'b0, step: 1'b0, dir: `SMC_DIR_FORWARD, current: 16'h0000};
         o_fb  <= '{mode: `SMC_MODE_STOPPED, steps_avail: 1'b0, steps_left: 16'h0000};
      end else begin
         o_drv.enable  <= state_reg != ST_IDLE;
         o_drv.current <= (state_reg != ST_IDLE) ? cur_val_reg : 16'h0000;
         o_drv.step    <= fire || pw_reg > 8'h01;
         // the driver latches direction at the step edge
         if (pw_reg == 8'h00 && !fire) o_drv.dir <= dir_eff;
         unique case (state_reg)
            ST_STEP: o_fb.mode <= `SMC_MODE_STEPPING;
            ST_HOLD: o_fb.mode <= `SMC_MODE_HOLDING;
            ST_RUN:  o_fb.mode <= `SMC_MODE_RUNNING;
            ST_IDLE: o_fb.mode <= mode_eff;
         endcase
         o_fb.steps_avail <= avail_reg;
         o_fb.steps_left  <= left_reg;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   reset_mode_a: assert property ($fell(i_rst) |-> o_fb.mode == `SMC_MODE_STOPPED)
      else $error("mode not stopped after reset");
   disable_off_a: assert property (mode_eff == `SMC_MODE_DISABLED |=> ##1 !o_drv.enable)
      else $error("current still on when disabled");
   step_count_a: assert property (done |-> mv_cnt_reg == mv_len_reg)
      else $error("move pulse count wrong");
   hold_level_a: assert property (state_reg == ST_HOLD |=> o_drv.enable && !o_drv.step)
      else $error("holding without current or with pulses");
   // the state follows a dropped run command one cycle later
   cont_run_a: assert property (state_reg == ST_RUN && !running |=> state_reg != ST_RUN)
      else $error("continuous stepping while not running");
   same_count_a: assert property (wr && hit(ap_addr_reg, `SMC_OFS_STEPS) && avail_reg &&
      i_hwdata[15:0] == steps_x_reg && !(mode_prev_reg == `SMC_MODE_STOPPED && running)
      |=> !arm_reg[0])
      else $error("unchanged count armed a move");
   tmo_clear_a: assert property (done && cfg_reg[`SMC_CFG_TMO_ZERO] &&
      !(wr && hit(ap_addr_reg, `SMC_OFS_STEPS)) |=> !avail_reg)
      else $error("count data still available");
   stop_end_a: assert property (done && mode_eff == `SMC_MODE_STOPPED && !go_step
      |=> state_reg == ST_IDLE ##1 !o_drv.enable)
      else $error("stopped move did not power down");
   pid_src_a: assert property (cfg_reg[`SMC_CFG_MODE_PID] |->
      cfg_reg[`SMC_CFG_DIR_PID] && cfg_reg[`SMC_CFG_RATE_PID])
      else $error("pid sources not linked");
   dir_stable_a: assert property (o_drv.step && $past(o_drv.step) |-> $stable(o_drv.dir))
      else $error("direction moved during pulse");

   move_hold_c: cover property (state_reg == ST_STEP ##1 state_reg == ST_HOLD);
   move_off_c: cover property (state_reg == ST_STEP ##1 state_reg == ST_IDLE);
   cont_c: cover property (state_reg == ST_RUN && fire);

endmodule

`default_nettype wire

// file: testbench/smc_host.sv
// ahb-lite master standing in for the network host
// assumes the one slave's hreadyout is fed back as i_hready
`timescale 1ns/1ps
`default_nettype none
module smc_host (
   // bus clock and answer
   input  wire logic        i_clk,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_hrdata,
   // request side
   output var logic         o_hsel,
   output var logic [31:0]  o_haddr,
   output var logic [1:0]   o_htrans,
   output var logic         o_hwrite,
   output var logic [2:0]   o_hsize,
   output var logic [31:0]  o_hwdata
);
   initial begin
      {o_hsel, o_haddr, o_htrans, o_hwrite, o_hwdata} = '0;
      o_hsize = 3'h2;
   end
   // one whole-word transfer; waits on hready, never on a cycle count
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge i_clk);
      o_hsel   <= 1'b1;
      o_haddr  <= {24'h0, a};
      o_hwrite <= w;
      o_htrans <= 2'h2;
      do @(posedge i_clk); while (i_hready !== 1'b1);
      o_htrans <= 2'h0;
      o_hwdata <= d;
      do @(posedge i_clk); while (i_hready !== 1'b1);
      r = i_hrdata;
   endtask
endmodule
`default_nettype wire

// file: testbench/smc_top_tb.sv
// self-checking bench for the stepper motion command block
// assumes the host model drives the bus and pid inputs stay idle until the pid test
`include "smc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module smc_top_tb
   import smc_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1;
   logic hsel, hwrite, hrdy, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   smc_drv_type drv;
   smc_fb_type fb;
   smc_pid_type pid = '0;   // pid commands, only used once cfg selects them
   int num_errors = 0, check_count = 0, pulses = 0;
   smc_host host (.i_clk(clk), .i_hready(hrdy), .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr),
      .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
   smc_top dut (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
      .o_hreadyout(hrdy), .o_hresp(hresp), .i_pid(pid), .o_drv(drv), .o_fb(fb));
   initial forever #10 clk = ~clk;
   // pulse counter on the step line
   always @(posedge drv.step) pulses++;
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd);
   endtask
   // one move: wait for stepping, then for its end, then count
   task automatic move(input int n, input logic [2:0] m);
      int k;
      pulses = 0;
      k = 0;
      while (fb.mode !== `SMC_MODE_STEPPING && k < 100) begin @(posedge clk); k++; end
      check(fb.mode, `SMC_MODE_STEPPING);
      k = 0;
      while (fb.mode === `SMC_MODE_STEPPING && k < 20000) begin @(posedge clk); k++; end
      @(posedge clk);
      check(pulses, n);
      check(fb.mode, m);
      check(drv.enable, m == `SMC_MODE_HOLDING);
   endtask
   task automatic test_done;
      if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog: the moves need well under this span
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      test_done;
   end
   // reset values of the drive and the bus
   task automatic t_reset;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(fb.mode, `SMC_MODE_STOPPED);
      check(drv.dir, `SMC_DIR_FORWARD);
      check(drv.enable, 1'b0);
      check({hresp, hrdy}, 2'b01);
      check(hrdata, 32'h0);
   endtask
   // a counted move that ends holding, then the status word
   task automatic t_first_move;
      wr(`SMC_OFS_RATE_LIM, 32'h9c40_0000);
      wr(`SMC_OFS_RATE, 32'h64);
      wr(`SMC_OFS_CUR, 32'h32);
      wr(`SMC_OFS_MODE, 32'h2);
      wr(`SMC_OFS_STEPS, 32'h1);
      move(10, `SMC_MODE_HOLDING);
      check(drv.current, 16'h03e8);
      host.xfer(1'b0, `SMC_OFS_STATUS, 32'h0, rd);
      check(rd, {`SMC_MODE_HOLDING, 1'b1, 16'h0000});
      host.xfer(1'b0, 8'h3c, 32'h0, rd);
      check(rd, 32'h0);
   endtask
   // same count again is ignored, a mode toggle repeats the move
   task automatic t_rearm;
      pulses = 0;
      wr(`SMC_OFS_STEPS, 32'h1);
      repeat (1000) @(posedge clk);
      check(pulses, 0);
      wr(`SMC_OFS_DIR, 32'h0);
      wr(`SMC_OFS_MODE, 32'h1);
      wr(`SMC_OFS_MODE, 32'h2);
      move(10, `SMC_MODE_HOLDING);
      check(drv.dir, `SMC_DIR_REVERSE);
   endtask
   // the host de-energizes through the disabled mode
   task automatic t_disable;
      wr(`SMC_OFS_MODE, 32'h0);
      repeat (4) @(posedge clk);
      check({fb.mode, drv.enable, drv.current}, 20'h0);
   endtask
   // single shot: zero timeout clears availability after a move
   task automatic t_single_shot;
      wr(`SMC_OFS_CFG, 32'h2);
      wr(`SMC_OFS_MODE, 32'h2);
      wr(`SMC_OFS_STEPS, 32'h2);
      move(20, `SMC_MODE_HOLDING);
      check(fb.steps_avail, 1'b0);
      wr(`SMC_OFS_MODE, 32'h1);
      wr(`SMC_OFS_STEPS, 32'h2);
      move(20, `SMC_MODE_STOPPED);
      wr(`SMC_OFS_MODE, 32'h3);
      repeat (4) @(posedge clk);
      check(fb.mode, `SMC_MODE_STOPPED);
   endtask
   // zero count runs on, a quarter period of about 312 cycles
   task automatic t_continuous;
      wr(`SMC_OFS_STEPS, 32'h0);
      wr(`SMC_OFS_MODE, 32'h2);
      pulses = 0;
      repeat (1000) @(posedge clk);
      check(fb.mode, `SMC_MODE_RUNNING);
      check(pulses >= 3 && pulses <= 4, 1'b1);
   endtask
   // pid takes mode, direction and rate; current stays on registers
   task automatic t_pid;
      pid <= '{mode: `SMC_MODE_RUNNING, dir: `SMC_DIR_FORWARD, rate: 16'h0000};
      wr(`SMC_OFS_CFG, 32'h4);
      host.xfer(1'b0, `SMC_OFS_CFG, 32'h0, rd);
      check(rd, 32'h1c);
      repeat (60) @(posedge clk);
      check({fb.mode, drv.dir, drv.step}, {`SMC_MODE_RUNNING, `SMC_DIR_FORWARD, 1'b0});
      check(drv.current, 16'h03e8);
   endtask
   initial begin
      t_reset;
      t_first_move;
      t_rearm;
      t_disable;
      t_single_shot;
      t_continuous;
      t_pid;
      test_done;
   end
endmodule
`default_nettype wire
